// *** verilog/lcd_cmd_pkg.sv ***
// shared constants for the lcd command interpreter
package lcd_cmd_pkg;
   localparam logic [7:0] CMD_READ_MEM = 8'h0A;
   localparam logic [7:0] CMD_CURSOR_POS = 8'h0B;
   localparam logic [7:0] CMD_CURSOR_STYLE = 8'h0C;
   localparam logic [7:0] CMD_CONTRAST = 8'h0D;
   localparam logic [7:0] CMD_BACKLIGHT = 8'h0E;
   localparam logic [7:0] CMD_FAN_REPORT = 8'h10;
   localparam logic [7:0] CMD_FAN_POWER = 8'h11;
   localparam logic [7:0] CMD_WIRE_INFO = 8'h12;
   localparam logic [7:0] CMD_TEMP_REPORT = 8'h13;
   localparam logic [7:0] CMD_WIRE_XACT = 8'h14;
   localparam logic [7:0] CMD_KEY_REPORT = 8'h17;
   localparam logic [7:0] REPLY_FLAG = 8'h40;
   localparam logic [7:0] FAN_REPORT_TYPE = 8'h81;
   localparam logic [7:0] TEMP_REPORT_TYPE = 8'h82;
   localparam logic [7:0] GLYPH_LO = 8'h40;
   localparam logic [7:0] GLYPH_HI = 8'h7F;
   localparam logic [7:0] TEXT_LINE_BASE = 8'h80;
   localparam logic [7:0] TEXT_LINE_LAST = 8'h13;
   localparam logic [7:0] COL_MAX = 8'h13;
   localparam logic [7:0] ROW_MAX = 8'h03;
   localparam logic [7:0] CURSOR_STYLE_MAX = 8'h03;
   localparam logic [7:0] FAN_POWER_MAX = 8'h64;
   localparam logic [7:0] SLOT_MAX = 8'h0F;
   localparam logic [7:0] SLOT_NO_ADDR = 8'h10;
   localparam logic [7:0] MATCH_ROM = 8'h55;
   localparam int WRITE_MAX = 15;
   localparam int READ_MAX = 14;
   localparam logic [7:0] KEY_MASK_RESET = 8'hFF;
   localparam logic [7:0] BACKLIGHT_RESET = 8'h64;
   localparam logic [7:0] CONTRAST_RESET = 8'h40;
   localparam int CLK_MHZ = 125;
   localparam int EIGHTH_MS = 125;
   // one eighth of a second, floored (longest time)
   localparam int EIGHTH_CYC = EIGHTH_MS * 1000 * CLK_MHZ;
   localparam int TEMP_MS = 1000;
   localparam int TEMP_CYC = TEMP_MS * 1000 * CLK_MHZ;
   localparam int NUM_FANS = 4;
   localparam int NUM_SLOTS = 16;
endpackage : lcd_cmd_pkg

// *** verilog/lcd_ctl_if.sv ***
// carrier between interpreter and reply builder
`timescale 1ns/1ns
interface lcd_ctl_if;
   logic start;
   logic [7:0] rtype;
   logic [3:0] rlen;
   logic [7:0] rdata [0:14];
   logic busy;
   modport master (output start, output rtype, output rlen, output rdata,
      input busy);
   modport slave (input start, input rtype, input rlen, input rdata,
      output busy);
endinterface : lcd_ctl_if

// *** verilog/reply_sender.sv ***
// serialises one reply packet: type, length, payload bytes
`timescale 1ns/1ns
module reply_sender (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   lcd_ctl_if.slave ctl,
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   output logic tx_last_o,
   input wire logic tx_ready_i
);
   typedef struct packed {
      logic busy;
      logic [4:0] idx;
      logic [7:0] rtype;
      logic [3:0] rlen;
      logic [7:0] data;
      logic valid;
      logic last;
   } snd_t;
   snd_t s_reg, s_next;
   logic [7:0] buf_reg [0:14];

   always_comb begin
      s_next = s_reg;
      if (!s_reg.busy) begin
         if (ctl.start) begin
            s_next.busy = 1'b1;
            s_next.rtype = ctl.rtype;
            s_next.rlen = ctl.rlen;
            s_next.idx = 5'h00;
            s_next.data = ctl.rtype;
            s_next.valid = 1'b1;
            s_next.last = 1'b0;
         end
      end else if (tx_ready_i) begin
         // idx 0 type, 1 length, then payload
         s_next.idx = s_reg.idx + 5'h01;
         if (s_reg.last) begin
            s_next.busy = 1'b0;
            s_next.valid = 1'b0;
            s_next.last = 1'b0;
         end else if (s_reg.idx == 5'h00) begin
            s_next.data = {4'h0, s_reg.rlen};
            s_next.last = (s_reg.rlen == 4'h0);
         end else begin
            s_next.data = buf_reg[s_reg.idx[3:0] - 4'h1];
            s_next.last = (s_reg.idx == {1'b0, s_reg.rlen});
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_reg <= '0;
      end else if (ce_i) begin
         s_reg <= s_next;
         if (!s_reg.busy && ctl.start) begin
            buf_reg <= ctl.rdata;
         end
      end
   end

   assign ctl.busy = s_reg.busy;
   assign tx_data_o = s_reg.data;
   assign tx_valid_o = s_reg.valid;
   assign tx_last_o = s_reg.last;

   property p_type_first;
      @(posedge clk_i) disable iff (rst_i)
      ce_i && !s_reg.busy && ctl.start
         |=> tx_valid_o && tx_data_o == $past(ctl.rtype);
   endproperty
   a_type_first: assert property (p_type_first) else $error("reply does not open with its type");
endmodule : reply_sender

// *** verilog/lcd_cmd_core.sv ***
// command interpreter for display, fan, sensor bus and key settings
`timescale 1ns/1ns
module lcd_cmd_core #(
   parameter int EIGHTH_CYCLES = lcd_cmd_pkg::EIGHTH_CYC,
   parameter int TEMP_CYCLES = lcd_cmd_pkg::TEMP_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // command packet, fully received and checked upstream
   input wire logic cmd_valid_i,
   input wire logic [7:0] cmd_type_i,
   input wire logic [4:0] cmd_len_i,
   input wire logic [7:0] cmd_data_i [0:15],
   output logic cmd_ready_o,
   // display controller memory read port
   output logic mem_rd_o,
   output logic [7:0] mem_addr_o,
   input wire logic mem_done_i,
   input wire logic [63:0] mem_data_i,
   // sensor bus engine
   output logic wire_start_o,
   output logic wire_scan_o,
   output logic wire_addr_o,
   output logic [63:0] wire_rom_o,
   output logic [3:0] wire_wr_len_o,
   output logic [119:0] wire_wr_data_o,
   output logic [3:0] wire_rd_len_o,
   input wire logic wire_done_i,
   input wire logic [3:0] wire_found_i,
   input wire logic [63:0] wire_found_rom_i,
   input wire logic wire_found_we_i,
   input wire logic [111:0] wire_rd_data_i,
   // settings
   output logic [7:0] cursor_col_o,
   output logic [7:0] cursor_row_o,
   output logic [1:0] cursor_style_o,
   output logic [7:0] contrast_o,
   output logic [7:0] lcd_backlight_o,
   output logic [7:0] key_backlight_o,
   output logic [31:0] fan_power_o,
   output logic [15:0] temp_enable_o,
   output logic [7:0] key_mask_press_o,
   output logic [7:0] key_mask_release_o,
   output logic [3:0] fan_measure_o,
   // reply byte stream
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   output logic tx_last_o,
   input wire logic tx_ready_i
);
   typedef enum logic [2:0] {
      ST_SCAN, ST_IDLE, ST_MEM, ST_WIRE, ST_REPLY
   } st_t;
   typedef struct packed {
      st_t st;
      logic [7:0] col;
      logic [7:0] row;
      logic [1:0] style;
      logic [7:0] contrast;
      logic [7:0] lcd_bl;
      logic [7:0] key_bl;
      logic [31:0] fan_pwr;
      logic [3:0] fan_rep;
      logic [15:0] temp_en;
      logic [7:0] kmask_p;
      logic [7:0] kmask_r;
      logic [15:0] present;
      logic [7:0] cmd;
      logic [7:0] arg0;
      logic mem_rd;
      logic wire_go;
      logic [31:0] tick;
      logic [1:0] phase;
      logic [3:0] measure;
      logic [31:0] ttick;
      logic fan_due;
      logic temp_due;
      logic ready;
   } core_t;
   core_t r_reg, r_next;
   logic [63:0] rom_reg [0:15];
   lcd_ctl_if ctl ();
   logic [7:0] pl [0:14];
   logic go;
   logic [7:0] rt;
   logic [3:0] rl;
   logic txn_ok;

   reply_sender u_send (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .ctl(ctl),
      .tx_data_o(tx_data_o),
      .tx_valid_o(tx_valid_o),
      .tx_last_o(tx_last_o),
      .tx_ready_i(tx_ready_i)
   );
   assign ctl.start = go;
   assign ctl.rtype = rt;
   assign ctl.rlen = rl;
   assign ctl.rdata = pl;

   // valid text codes: base 0x80,0xA0,0xC0,0xE0 plus 0..19
   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a >= lcd_cmd_pkg::GLYPH_LO && a <= lcd_cmd_pkg::GLYPH_HI)
         || (a[7] && a[4:0] <= lcd_cmd_pkg::TEXT_LINE_LAST[4:0]);
   endfunction : addr_ok

   always_comb begin
      txn_ok = cmd_len_i >= 5'd2
         && cmd_len_i <= 5'(lcd_cmd_pkg::WRITE_MAX + 2)
         && cmd_data_i[0] <= lcd_cmd_pkg::SLOT_NO_ADDR
         && cmd_data_i[1] <= 8'(lcd_cmd_pkg::READ_MAX);
   end

   always_comb begin
      r_next = r_reg;
      go = 1'b0;
      rt = 8'h00;
      rl = 4'h0;
      for (int i = 0; i < 15; i++) pl[i] = 8'h00;
      r_next.mem_rd = 1'b0;
      r_next.wire_go = 1'b0;
      // half second cycle split into four eighth-second fan slots
      if (r_reg.tick >= EIGHTH_CYCLES - 1) begin
         r_next.tick = '0;
         r_next.phase = r_reg.phase + 2'd1;
         r_next.measure = r_reg.fan_rep & (4'h1 << r_reg.phase);
         if (r_reg.fan_rep[r_reg.phase]) r_next.fan_due = 1'b1;
      end else begin
         r_next.tick = r_reg.tick + 32'd1;
      end
      if (r_reg.ttick >= TEMP_CYCLES - 1) begin
         r_next.ttick = '0;
         if (|r_reg.temp_en) r_next.temp_due = 1'b1;
      end else begin
         r_next.ttick = r_reg.ttick + 32'd1;
      end
      r_next.ready = 1'b0;
      unique case (r_reg.st)
         ST_SCAN: begin
            if (wire_done_i) r_next.st = ST_IDLE;
         end
         ST_IDLE: begin
            if (!ctl.busy && r_reg.fan_due) begin
               // report of fan slot just measured; speed supplied upstream
               r_next.fan_due = 1'b0;
               go = 1'b1;
               rt = lcd_cmd_pkg::FAN_REPORT_TYPE;
               rl = 4'h1;
               pl[0] = {6'h00, r_reg.phase - 2'd1};
            end else if (!ctl.busy && r_reg.temp_due) begin
               r_next.temp_due = 1'b0;
               go = 1'b1;
               rt = lcd_cmd_pkg::TEMP_REPORT_TYPE;
               rl = 4'h2;
               pl[0] = r_reg.temp_en[7:0];
               pl[1] = r_reg.temp_en[15:8];
            end else if (!ctl.busy && cmd_valid_i) begin
               r_next.ready = 1'b1;
               r_next.cmd = cmd_type_i;
               r_next.arg0 = cmd_data_i[0];
               r_next.st = ST_REPLY;
               unique case (cmd_type_i)
                  lcd_cmd_pkg::CMD_READ_MEM:
                     if (cmd_len_i == 5'd1 && addr_ok(cmd_data_i[0])) begin
                        r_next.mem_rd = 1'b1;
                        r_next.st = ST_MEM;
                     end else r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_CURSOR_POS:
                     if (cmd_len_i == 5'd2 && cmd_data_i[0] <= lcd_cmd_pkg::COL_MAX
                        && cmd_data_i[1] <= lcd_cmd_pkg::ROW_MAX) begin
                        r_next.col = cmd_data_i[0];
                        r_next.row = cmd_data_i[1];
                     end else r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_CURSOR_STYLE:
                     if (cmd_len_i == 5'd1
                        && cmd_data_i[0] <= lcd_cmd_pkg::CURSOR_STYLE_MAX)
                        r_next.style = cmd_data_i[0][1:0];
                     else r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_CONTRAST:
                     if (cmd_len_i == 5'd1) r_next.contrast = cmd_data_i[0];
                     else r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_BACKLIGHT:
                     if (cmd_len_i == 5'd1) begin
                        r_next.lcd_bl = cmd_data_i[0];
                        r_next.key_bl = cmd_data_i[0];
                     end else if (cmd_len_i == 5'd2) begin
                        r_next.lcd_bl = cmd_data_i[0];
                        r_next.key_bl = cmd_data_i[1];
                     end else r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_FAN_REPORT:
                     if (cmd_len_i == 5'd1) r_next.fan_rep = cmd_data_i[0][3:0];
                     else r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_FAN_POWER:
                     if (cmd_len_i == 5'd4
                        && cmd_data_i[0] <= lcd_cmd_pkg::FAN_POWER_MAX
                        && cmd_data_i[1] <= lcd_cmd_pkg::FAN_POWER_MAX
                        && cmd_data_i[2] <= lcd_cmd_pkg::FAN_POWER_MAX
                        && cmd_data_i[3] <= lcd_cmd_pkg::FAN_POWER_MAX)
                        r_next.fan_pwr = {cmd_data_i[3], cmd_data_i[2],
                           cmd_data_i[1], cmd_data_i[0]};
                     else r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_WIRE_INFO:
                     if (!(cmd_len_i == 5'd1 && cmd_data_i[0] <= lcd_cmd_pkg::SLOT_MAX))
                        r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_TEMP_REPORT:
                     if (cmd_len_i == 5'd4 && cmd_data_i[2] == 8'h00
                        && cmd_data_i[3] == 8'h00)
                        r_next.temp_en = {cmd_data_i[1], cmd_data_i[0]};
                     else r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_WIRE_XACT:
                     if (txn_ok) begin
                        r_next.wire_go = 1'b1;
                        r_next.st = ST_WIRE;
                     end else r_next.st = ST_IDLE;
                  lcd_cmd_pkg::CMD_KEY_REPORT:
                     if (cmd_len_i == 5'd2) begin
                        r_next.kmask_p = cmd_data_i[0];
                        r_next.kmask_r = cmd_data_i[1];
                     end else r_next.st = ST_IDLE;
                  default: r_next.st = ST_IDLE; // other commands handled elsewhere
               endcase
            end
         end
         ST_MEM: begin
            // done still stands from the previous read while the pulse is out
            if (!r_reg.mem_rd && mem_done_i && !ctl.busy) begin
               go = 1'b1;
               rt = lcd_cmd_pkg::REPLY_FLAG | r_reg.cmd;
               rl = 4'h9;
               pl[0] = r_reg.arg0;
               for (int i = 0; i < 8; i++) pl[i + 1] = mem_data_i[i * 8 +: 8];
               r_next.st = ST_IDLE;
            end
         end
         ST_WIRE: begin
            if (wire_done_i && !ctl.busy) begin
               go = 1'b1;
               rt = lcd_cmd_pkg::REPLY_FLAG | r_reg.cmd;
               rl = 4'(cmd_data_i[1]);
               for (int i = 0; i < 14; i++) pl[i] = wire_rd_data_i[i * 8 +: 8];
               r_next.st = ST_IDLE;
            end
         end
         ST_REPLY: begin
            if (!ctl.busy) begin
               go = 1'b1;
               rt = lcd_cmd_pkg::REPLY_FLAG | r_reg.cmd;
               if (r_reg.cmd == lcd_cmd_pkg::CMD_WIRE_INFO) begin
                  rl = 4'h9;
                  pl[0] = r_reg.arg0;
                  for (int i = 0; i < 8; i++)
                     pl[i + 1] = rom_reg[r_reg.arg0[3:0]][i * 8 +: 8];
               end
               r_next.st = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg <= '0;
         r_reg.st <= ST_SCAN;
         r_reg.contrast <= lcd_cmd_pkg::CONTRAST_RESET;
         r_reg.lcd_bl <= lcd_cmd_pkg::BACKLIGHT_RESET;
         r_reg.key_bl <= lcd_cmd_pkg::BACKLIGHT_RESET;
         r_reg.kmask_p <= lcd_cmd_pkg::KEY_MASK_RESET;
         r_reg.kmask_r <= lcd_cmd_pkg::KEY_MASK_RESET;
         r_reg.wire_go <= 1'b1;
      end else if (ce_i) begin
         r_reg <= r_next;
         if (wire_found_we_i && r_reg.st == ST_SCAN) begin
            rom_reg[wire_found_i] <= wire_found_rom_i;
            r_reg.present[wire_found_i] <= 1'b1;
         end
      end
   end

   // address prefix only for a slot found during the scan
   always_comb begin
      wire_addr_o = r_reg.arg0 < lcd_cmd_pkg::SLOT_NO_ADDR
         && r_reg.present[r_reg.arg0[3:0]];
      wire_rom_o = rom_reg[r_reg.arg0[3:0]];
      wire_wr_len_o = 4'(cmd_len_i - 5'd2);
      for (int i = 0; i < 15; i++) wire_wr_data_o[i * 8 +: 8] = cmd_data_i[i + 2 > 15 ? 15 : i + 2];
      wire_rd_len_o = cmd_data_i[1][3:0];
   end

   assign cmd_ready_o = r_reg.ready;
   assign mem_rd_o = r_reg.mem_rd;
   assign mem_addr_o = r_reg.arg0;
   assign wire_start_o = r_reg.wire_go;
   assign wire_scan_o = (r_reg.st == ST_SCAN);
   assign cursor_col_o = r_reg.col;
   assign cursor_row_o = r_reg.row;
   assign cursor_style_o = r_reg.style;
   assign contrast_o = r_reg.contrast;
   assign lcd_backlight_o = r_reg.lcd_bl;
   assign key_backlight_o = r_reg.key_bl;
   assign fan_power_o = r_reg.fan_pwr;
   assign temp_enable_o = r_reg.temp_en;
   assign key_mask_press_o = r_reg.kmask_p;
   assign key_mask_release_o = r_reg.kmask_r;
   assign fan_measure_o = r_reg.measure;

   property p_pos_reject;
      @(posedge clk_i) disable iff (rst_i)
      ce_i && r_reg.st == ST_IDLE && !ctl.busy && !r_reg.fan_due
         && !r_reg.temp_due && cmd_valid_i
         && cmd_type_i == lcd_cmd_pkg::CMD_CURSOR_POS
         && cmd_data_i[0] > lcd_cmd_pkg::COL_MAX |=> $stable(cursor_col_o);
   endproperty
   a_pos_reject: assert property (p_pos_reject) else $error("bad column stored");
   property p_bl_one;
      @(posedge clk_i) disable iff (rst_i)
      ce_i && r_reg.st == ST_IDLE && !ctl.busy && !r_reg.fan_due
         && !r_reg.temp_due && cmd_valid_i
         && cmd_type_i == lcd_cmd_pkg::CMD_BACKLIGHT && cmd_len_i == 5'd1
         |=> lcd_backlight_o == key_backlight_o;
   endproperty
   a_bl_one: assert property (p_bl_one) else $error("backlights differ");
   property p_fan_max;
      @(posedge clk_i) disable iff (rst_i)
      fan_power_o[7:0] <= lcd_cmd_pkg::FAN_POWER_MAX;
   endproperty
   a_fan_max: assert property (p_fan_max) else $error("fan power above 100");
   property p_measure_one;
      @(posedge clk_i) disable iff (rst_i) $countones(fan_measure_o) <= 1;
   endproperty
   a_measure_one: assert property (p_measure_one) else $error("two fans forced");
   property p_skip_addr;
      @(posedge clk_i) disable iff (rst_i)
      r_reg.arg0 == lcd_cmd_pkg::SLOT_NO_ADDR |-> !wire_addr_o;
   endproperty
   a_skip_addr: assert property (p_skip_addr) else $error("slot 16 addressed");
   property p_key_default;
      @(posedge clk_i) $fell(rst_i) |-> key_mask_press_o == 8'hFF;
   endproperty
   a_key_default: assert property (p_key_default) else $error("keys masked at reset");
   property p_mem_reply;
      @(posedge clk_i) disable iff (rst_i)
      ce_i && r_reg.st == ST_MEM && go |-> rl == 4'h9 && pl[0] == mem_addr_o;
   endproperty
   a_mem_reply: assert property (p_mem_reply) else $error("memory reply malformed");
   property p_cmd_reply;
      @(posedge clk_i) disable iff (rst_i)
      ce_i && r_reg.st == ST_REPLY && go |-> rt == (r_reg.cmd | 8'h40);
   endproperty
   a_cmd_reply: assert property (p_cmd_reply) else $error("reply type wrong");
   c_mem: cover property (@(posedge clk_i) ce_i && r_reg.st == ST_MEM && go);
   c_wire: cover property (@(posedge clk_i) ce_i && r_reg.st == ST_WIRE && go);
   c_fan: cover property (@(posedge clk_i) r_reg.fan_due && go);
endmodule : lcd_cmd_core

// *** verif/far_side.sv ***
// display controller and sensor bus engine seen from the interpreter
`timescale 1ns/1ns
module far_side #(
   parameter logic [63:0] ROM = 64'h1E2D3C4B5A697887
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic mem_rd_o,
   input wire logic [7:0] mem_addr_o,
   input wire logic wire_start_o,
   input wire logic wire_scan_o,
   output logic mem_done_i,
   output logic [63:0] mem_data_i,
   output logic wire_done_i,
   output logic wire_found_we_i,
   output logic [3:0] wire_found_i,
   output logic [63:0] wire_found_rom_i,
   output logic [111:0] wire_rd_data_i
);
   logic [3:0] mcnt_reg;
   logic [3:0] wcnt_reg;
   logic [7:0] addr_reg;
   assign wire_found_i = 4'h0;
   assign wire_found_rom_i = ROM;
   assign wire_rd_data_i = {7{16'hA55A}};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mcnt_reg <= 4'h0;
         wcnt_reg <= 4'h0;
         mem_done_i <= 1'b0;
         mem_data_i <= 64'h0;
         wire_done_i <= 1'b0;
         wire_found_we_i <= 1'b0;
      end else begin
         wire_done_i <= (wcnt_reg == 4'h1);
         // slot 0 recorded while the power-up scan runs
         wire_found_we_i <= (wcnt_reg == 4'h2) && wire_scan_o;
         wcnt_reg <= wire_start_o ? 4'h5 : wcnt_reg - (wcnt_reg != 4'h0);
         mcnt_reg <= mem_rd_o ? 4'h3 : mcnt_reg - (mcnt_reg != 4'h0);
         if (mem_rd_o) begin
            addr_reg <= mem_addr_o;
            mem_done_i <= 1'b0;
            // stale data scrambled so a missed wait shows up
            mem_data_i <= ~mem_data_i;
         end else if (mcnt_reg == 4'h1) begin
            mem_done_i <= 1'b1;
            mem_data_i <= {8{addr_reg}} ^ 64'h0706050403020100;
         end
      end
   end
endmodule : far_side

// *** verif/testbench.sv ***
// self-checking bench for the command interpreter
`timescale 1ns/1ns
module testbench;
   typedef struct packed {
      logic [7:0] t;
      logic [4:0] l;
      logic [7:0] a, b, c, d;
   } row_t;
   localparam logic [63:0] ROM = 64'h1E2D3C4B5A697887;
   logic clk_i = 0, rst_i = 1, ce_i = 1, cmd_valid_i = 0, tx_ready_i = 1;
   logic [7:0] cmd_type_i = 8'h00;
   logic [4:0] cmd_len_i = 5'h00;
   logic [7:0] cmd_data_i [0:15];
   logic cmd_ready_o, mem_rd_o, mem_done_i, wire_start_o, wire_scan_o;
   logic wire_addr_o, wire_done_i, wire_found_we_i, tx_valid_o, tx_last_o;
   logic [7:0] mem_addr_o, cursor_col_o, cursor_row_o, contrast_o, tx_data_o;
   logic [7:0] lcd_backlight_o, key_backlight_o;
   logic [7:0] key_mask_press_o, key_mask_release_o;
   logic [63:0] mem_data_i, wire_rom_o, wire_found_rom_i;
   logic [3:0] wire_wr_len_o, wire_rd_len_o, wire_found_i, fan_measure_o;
   logic [119:0] wire_wr_data_o;
   logic [111:0] wire_rd_data_i;
   logic [1:0] cursor_style_o;
   logic [31:0] fan_power_o;
   logic [15:0] temp_enable_o;
   logic [7:0] rx [0:31];
   logic [7:0] maddr [0:1] = '{8'h40, 8'hF3};
   int nrx, n_errors = 0, n_tests = 0;
   row_t rows [0:7] = '{
      '{8'h0B, 5'h02, 8'h13, 8'h03, 8'h00, 8'h00},
      '{8'h0C, 5'h01, 8'h03, 8'h00, 8'h00, 8'h00},
      '{8'h0E, 5'h01, 8'h30, 8'h00, 8'h00, 8'h00},
      '{8'h0E, 5'h02, 8'h11, 8'h77, 8'h00, 8'h00},
      '{8'h11, 5'h04, 8'h64, 8'h05, 8'h00, 8'h32},
      '{8'h17, 5'h02, 8'h0F, 8'hF0, 8'h00, 8'h00},
      '{8'h0D, 5'h01, 8'h2A, 8'h00, 8'h00, 8'h00},
      '{8'h0B, 5'h02, 8'h13, 8'h04, 8'h00, 8'h00}};
   lcd_cmd_core #(.EIGHTH_CYCLES(20), .TEMP_CYCLES(100)) u_dut (.clk_i,
      .rst_i, .ce_i, .cmd_valid_i, .cmd_type_i, .cmd_len_i, .cmd_data_i,
      .cmd_ready_o, .mem_rd_o, .mem_addr_o, .mem_done_i, .mem_data_i,
      .wire_start_o, .wire_scan_o, .wire_addr_o, .wire_rom_o, .wire_wr_len_o,
      .wire_wr_data_o, .wire_rd_len_o, .wire_done_i, .wire_found_i,
      .wire_found_rom_i, .wire_found_we_i, .wire_rd_data_i, .cursor_col_o,
      .cursor_row_o, .cursor_style_o, .contrast_o, .lcd_backlight_o,
      .key_backlight_o, .fan_power_o, .temp_enable_o, .key_mask_press_o,
      .key_mask_release_o, .fan_measure_o, .tx_data_o, .tx_valid_o,
      .tx_last_o, .tx_ready_i);
   far_side #(.ROM(ROM)) u_far (.clk_i, .rst_i, .mem_rd_o, .mem_addr_o,
      .wire_start_o, .wire_scan_o, .mem_done_i, .mem_data_i, .wire_done_i,
      .wire_found_we_i, .wire_found_i, .wire_found_rom_i, .wire_rd_data_i);
   initial forever #4 clk_i = ~clk_i;
   task automatic stop_test();
      if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [63:0] s, e);
      n_tests++;
      if (s !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   // drives one packet, then gathers the reply bytes that follow it
   task automatic send(input row_t r);
      int k;
      @(posedge clk_i);
      cmd_type_i <= r.t;
      cmd_len_i <= r.l;
      cmd_data_i[0] <= r.a;
      cmd_data_i[1] <= r.b;
      cmd_data_i[2] <= r.c;
      cmd_data_i[3] <= r.d;
      cmd_valid_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (cmd_ready_o !== 1'b1 && k < 200);
      cmd_valid_i <= 1'b0;
      if (k == 200) begin
         n_errors++;
         stop_test();
      end
      nrx = 0;
      for (k = 0; k < 40; k++) begin
         @(posedge clk_i);
         if (tx_valid_o === 1'b1) begin
            rx[nrx] = tx_data_o;
            nrx++;
            if (tx_last_o === 1'b1) break;
         end
      end
   endtask : send
   task automatic ack(input logic [7:0] t);
      chk("count", nrx, 2);
      chk("type", rx[0], t | lcd_cmd_pkg::REPLY_FLAG);
      chk("len", rx[1], 8'h00);
   endtask : ack
   initial begin
      for (int j = 0; j < 16; j++) cmd_data_i[j] = 8'h00;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk("scan", wire_scan_o, 1'b1);
      chk("contrast", contrast_o, 8'h40);
      chk("bl", {lcd_backlight_o, key_backlight_o}, 16'h6464);
      chk("keys", {key_mask_press_o, key_mask_release_o}, 16'hFFFF);
      for (int i = 0; i < 7; i++) begin
         send(rows[i]);
         ack(rows[i].t);
         if (i == 2) chk("bl", lcd_backlight_o, key_backlight_o);
      end
      send(rows[7]);
      chk("refused", nrx, 0);
      send('{8'h11, 5'h04, 8'h65, 8'h00, 8'h00, 8'h00});
      chk("refused", nrx, 0);
      chk("cursor", {cursor_col_o, cursor_row_o}, 16'h1303);
      chk("style", cursor_style_o, 2'h3);
      chk("bl", {lcd_backlight_o, key_backlight_o}, 16'h1177);
      chk("fan", fan_power_o, 32'h32000564);
      chk("contrast", contrast_o, 8'h2A);
      chk("keys", {key_mask_press_o, key_mask_release_o}, 16'h0FF0);
      foreach (maddr[i]) begin
         send('{8'h0A, 5'h01, maddr[i], 8'h00, 8'h00, 8'h00});
         chk("count", nrx, 11);
         chk("head", {rx[0], rx[1], rx[2]}, {16'h4A09, maddr[i]});
         for (int j = 0; j < 8; j++) chk("mem", rx[3 + j], maddr[i] ^ 8'(j));
      end
      send('{8'h12, 5'h01, 8'h00, 8'h00, 8'h00, 8'h00});
      chk("head", {rx[0], rx[1], rx[2]}, 24'h520900);
      for (int j = 0; j < 8; j++) chk("rom", rx[3 + j], ROM[8 * j +: 8]);
      send('{8'h12, 5'h01, 8'h10, 8'h00, 8'h00, 8'h00});
      chk("refused", nrx, 0);
      send('{8'h14, 5'h03, 8'h10, 8'h02, 8'hAB, 8'h00});
      chk("type", rx[0], 8'h54);
      chk("read", {rx[2], rx[3]}, 16'h5AA5);
      chk("addr", wire_addr_o, 1'b0);
      chk("write", {wire_wr_len_o, wire_wr_data_o[7:0]}, 12'h1AB);
      chk("rd len", wire_rd_len_o, 4'h2);
      send('{8'h14, 5'h02, 8'h00, 8'h00, 8'h00, 8'h00});
      chk("count", nrx, 2);
      chk("addr", {wire_addr_o, wire_rom_o}, {1'b1, ROM});
      chk("wr len", wire_wr_len_o, 4'h0);
      // the command writes 0x01 to the low enable byte, so only slot 0's bit is set
      send('{8'h13, 5'h04, 8'h01, 8'h00, 8'h00, 8'h00});
      ack(8'h13);
      chk("temp", temp_enable_o, 16'h0001);
      send('{8'h10, 5'h01, 8'h01, 8'h00, 8'h00, 8'h00});
      ack(8'h10);
      nrx = 0;
      while (nrx < 200 && !(tx_valid_o === 1'b1 && tx_data_o === 8'h81)) begin
         @(posedge clk_i);
         nrx++;
      end
      chk("fan rep", nrx < 200, 1'b1);
      chk("measure", fan_measure_o, 4'h1);
      stop_test();
   end
endmodule : testbench
